// file: spi_host_cfg.svh
// Register offsets, field positions, reset values and timing counts of the serial register-access host.
`ifndef SPI_HOST_CFG_SVH
`define SPI_HOST_CFG_SVH

// Offsets of the host's own APB registers (byte addresses, one word each).
`define OFS_CTRL 12'h000
`define OFS_TARGET 12'h004
`define OFS_WDATA 12'h008
`define OFS_RDATA 12'h00c
`define OFS_STATUS 12'h010
`define OFS_DIV 12'h014

// Control register fields.
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_FAST 2

// Target register fields: double-word address and byte-lane enables.
`define TGT_ADDR_LSB 2
`define TGT_ADDR_MSB 10
`define TGT_BE_LSB 12
`define TGT_BE_MSB 15

// Status register fields.
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_REFUSED 2

// Reset values.
`define TARGET_RESET 32'h00003000
`define DIV_RESET 8'h04
`define CTRL_RESET 2'h0

// Serial command layout.
`define OP_READ 1'h0
`define OP_WRITE 1'h1
`define CMD_BITS 6'h10
`define TURNAROUND_BITS 2'h0

// Device register that reports which serial configuration interface was strapped.
`define DEV_CONFIG_STATUS_REG 11'h0d8

`endif

// file: spi_host_pkg.sv
// Types and byte-lane decoding shared by the serial register-access host.
package spi_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_HIGH,
    ST_LOW,
    ST_TRAIL,
    ST_GAP
  } frame_state_t;

  // True for the lane patterns the device accepts: one byte, either half, or all four.
  function automatic logic be_legal(input logic [3:0] be);
    case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_legal = 1'b1;
      default: be_legal = 1'b0;
    endcase
  endfunction

  // Number of enabled lanes.
  function automatic logic [2:0] be_count(input logic [3:0] be);
    be_count = 3'(be[0]) + 3'(be[1]) + 3'(be[2]) + 3'(be[3]);
  endfunction

  // Lowest enabled lane; legal patterns are contiguous, so this is the first byte sent.
  function automatic logic [1:0] be_first(input logic [3:0] be);
    if (be[0]) begin
      be_first = 2'h0;
    end else if (be[1]) begin
      be_first = 2'h1;
    end else if (be[2]) begin
      be_first = 2'h2;
    end else begin
      be_first = 2'h3;
    end
  endfunction

endpackage

// file: spi_half_tick.sv
// Divider that turns pclk into one-cycle enables, one per half period of the serial clock.
`timescale 1ns/100ps
`default_nettype none
module spi_half_tick #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [W-1:0] half_cycles,
  output logic tick
);

  logic [W-1:0] count;
  wire logic count_end = (count >= half_cycles - W'(1)) || (half_cycles == '0);

  // The count restarts whenever a frame is not running, so every frame starts on a full half period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!run || count_end) begin
      count <= '0;
    end else begin
      count <= count + W'(1);
    end
  end

  assign tick = run && count_end;

endmodule
`default_nettype wire

// file: spi_lane_codec.sv
// Packs enabled write lanes into serial order and spreads received bytes back onto their lanes.
`timescale 1ns/100ps
`default_nettype none
module spi_lane_codec
  import spi_host_pkg::*;
(
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rx_bits,
  output logic [31:0] payload,
  output logic [31:0] lanes
);

  wire logic [2:0] nbytes = be_count(be);
  wire logic [1:0] first = be_first(be);

  // Byte 0 of the access leaves first, so the lowest enabled lane lands in the top byte of payload.
  always_comb begin
    payload = '0;
    lanes = '0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < nbytes) begin
        payload[31 - 8 * i -: 8] = wdata[8 * (int'(first) + i) +: 8];
        lanes[8 * (int'(first) + i) +: 8] = rx_bits[8 * (int'(nbytes) - 1 - i) +: 8];
      end
    end
  end

endmodule
`default_nettype wire

// file: spi_reg_host.sv
// APB-programmed master that reads and writes device registers over the four-wire serial port.
//
// What this block does
// - Each select-low period is one whole operation, opened and closed by the master.
// - Serial clock idles low whenever no operation is running.
// - Master drives clock, select and serial input; only the device drives serial output.
// - High-speed: output launched on rise, master samples on the following fall.
// - Low-speed: output launched on fall, master samples on the next rise.
// - First command bit is the opcode: zero reads, one writes.
// - Two command bytes, then one to four data bytes chosen by lane enables.
// - Command order: opcode, address 10..2, enables 3..0, two zero turnaround bits.
// - Only single bytes, either half or all four lanes may be enabled.
// - Enable codes are 0011 or 1100 for two bytes, 0001, 0010, 0100 or 1000 for one, 1111 for four.
// - Byte 0 goes first, byte 3 last; each byte is most significant bit first.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "spi_host_cfg.svh"
module spi_reg_host
  import spi_host_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic select_low_pin,
  output logic serial_clk_pin,
  output logic serial_in_pin,
  input wire logic serial_out_pin
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic op_write;
  logic fast_mode;
  logic [31:0] target;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic done;
  logic refused;
  logic [DIV_W-1:0] half_cycles;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame state.

  frame_state_t state;
  logic [47:0] tx_shift;
  logic [31:0] rx_shift;
  logic [5:0] bit_idx;
  logic [5:0] last_bit;
  logic frame_write;
  logic frame_fast;
  logic [3:0] frame_be;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode.

  // Zero wait states: every access completes in its first access cycle.
  wire logic setup_phase = psel && !penable;
  wire logic access_phase = psel && penable;
  wire logic wr_strobe = access_phase && pwrite;
  wire logic hit_ctrl = (paddr == `OFS_CTRL);
  wire logic hit_target = (paddr == `OFS_TARGET);
  wire logic hit_wdata = (paddr == `OFS_WDATA);
  wire logic hit_rdata = (paddr == `OFS_RDATA);
  wire logic hit_status = (paddr == `OFS_STATUS);
  wire logic hit_div = (paddr == `OFS_DIV);
  wire logic hit_any = hit_ctrl || hit_target || hit_wdata || hit_rdata || hit_status || hit_div;

  assign pready = 1'b1;
  assign pslverr = access_phase && !hit_any;

  ////////////////////////////////////////////////////////////////////////////////
  // Start decision.

  wire logic busy = (state != ST_IDLE);
  wire logic [3:0] req_be = target[`TGT_BE_MSB:`TGT_BE_LSB];
  wire logic go_req = wr_strobe && hit_ctrl && pwdata[`CTRL_GO];
  // The lane pattern is checked before anything reaches the pins, since the device has no
  // way to answer a pattern it does not support.
  wire logic be_ok = be_legal(req_be);
  wire logic start = go_req && !busy && be_ok;
  wire logic refuse = go_req && (busy || !be_ok);

  // Opcode and the mode travel with the control write that starts the frame.
  wire logic start_write = pwdata[`CTRL_WRITE];
  wire logic start_fast = pwdata[`CTRL_FAST];

  ////////////////////////////////////////////////////////////////////////////////
  // Command and data packing.

  logic [31:0] payload;
  logic [31:0] lanes;

  // During a frame the codec sees the latched enables, so unpacking stays tied to the frame.
  wire logic [3:0] codec_be = busy ? frame_be : req_be;

  spi_lane_codec u_codec (
    .be(codec_be),
    .wdata(wdata),
    .rx_bits(rx_shift),
    .payload(payload),
    .lanes(lanes)
  );

  // Opcode, address 10..2, lane enables 3..0 and two zero turnaround bits.
  wire logic [15:0] command = {start_write, target[`TGT_ADDR_MSB:`TGT_ADDR_LSB], req_be, `TURNAROUND_BITS};

  // Reads send zeros on the serial input during the data phase.
  wire logic [31:0] send_data = start_write ? payload : 32'h00000000;
  wire logic [5:0] start_last = `CMD_BITS + {be_count(req_be), 3'h0} - 6'h01;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock enable.

  logic tick;

  spi_half_tick #(
    .W(DIV_W)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(busy),
    .half_cycles(half_cycles),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Edge events.

  // A rising edge is made from the lead-in and from every low half; a falling edge from every high half.
  wire logic rise_now = tick && ((state == ST_LEAD) || (state == ST_LOW));
  wire logic fall_now = tick && (state == ST_HIGH);
  wire logic last_fall = fall_now && (bit_idx == last_bit);
  wire logic in_data = (bit_idx >= `CMD_BITS);
  // High-speed output is launched on our rise and is stable at the next fall; low-speed output
  // is launched on the fall before and is stable at the rise.
  wire logic sample_fast = frame_fast && fall_now;
  wire logic sample_slow = !frame_fast && rise_now;
  wire logic sample_now = !frame_write && in_data && (sample_fast || sample_slow);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer.

  // Select falls one half period before the first rise and rises one half period after the last fall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            state <= (bit_idx == last_bit) ? ST_TRAIL : ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            state <= ST_HIGH;
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            state <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tick) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Select is low for exactly one whole operation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_low_pin <= 1'b1;
    end else if (start) begin
      select_low_pin <= 1'b0;
    end else if (tick && (state == ST_TRAIL)) begin
      select_low_pin <= 1'b1;
    end
  end

  // The clock only moves while select is low and always comes back to rest low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clk_pin <= 1'b0;
    end else if (rise_now) begin
      serial_clk_pin <= 1'b1;
    end else if (fall_now) begin
      serial_clk_pin <= 1'b0;
    end
  end

  // Each bit changes on a fall, so it is settled half a period before the device samples it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift <= '0;
      serial_in_pin <= 1'b0;
    end else if (start) begin
      tx_shift <= {command, send_data};
      serial_in_pin <= start_write;
    end else if (fall_now) begin
      tx_shift <= {tx_shift[46:0], 1'b0};
      serial_in_pin <= last_fall ? 1'b0 : tx_shift[46];
    end
  end

  // Bit position and frame parameters, held for the whole frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_idx <= '0;
      last_bit <= '0;
      frame_write <= 1'b0;
      frame_fast <= 1'b0;
      frame_be <= '0;
    end else if (start) begin
      bit_idx <= '0;
      last_bit <= start_last;
      frame_write <= start_write;
      frame_fast <= start_fast;
      frame_be <= req_be;
    end else if (fall_now) begin
      bit_idx <= bit_idx + 6'h01;
    end
  end

  // Returned bits collect most significant first; the codec puts bytes back onto lanes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift <= '0;
    end else if (start) begin
      rx_shift <= '0;
    end else if (sample_now) begin
      rx_shift <= {rx_shift[30:0], serial_out_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software-visible registers.

  wire logic frame_end = tick && (state == ST_GAP);

  // Control and target hold their last written value; a write while busy only changes
  // what the next frame will use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {fast_mode, op_write} <= `CTRL_RESET;
      target <= `TARGET_RESET;
      wdata <= '0;
      half_cycles <= DIV_W'(`DIV_RESET);
    end else if (wr_strobe) begin
      if (hit_ctrl) begin
        op_write <= pwdata[`CTRL_WRITE];
        fast_mode <= pwdata[`CTRL_FAST];
      end
      if (hit_target) begin
        target <= pwdata & 32'h0000f7fc;
      end
      if (hit_wdata) begin
        wdata <= pwdata;
      end
      if (hit_div) begin
        half_cycles <= pwdata[DIV_W-1:0];
      end
    end
  end

  // Read data lands when the frame closes; lanes that were not enabled read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (frame_end && !frame_write) begin
      rdata <= lanes;
    end
  end

  // Sticky flags: a new event in the same cycle as a clear keeps the flag set.
  wire logic clr_done = wr_strobe && hit_status && pwdata[`STAT_DONE];
  wire logic clr_refused = wr_strobe && hit_status && pwdata[`STAT_REFUSED];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      refused <= 1'b0;
    end else begin
      done <= frame_end || (done && !clr_done);
      refused <= refuse || (refused && !clr_refused);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB read mux.

  logic [31:0] read_word;

  always_comb begin
    read_word = 32'h00000000;
    if (hit_ctrl) begin
      read_word[`CTRL_WRITE] = op_write;
      read_word[`CTRL_FAST] = fast_mode;
    end else if (hit_target) begin
      read_word = target;
    end else if (hit_wdata) begin
      read_word = wdata;
    end else if (hit_rdata) begin
      read_word = rdata;
    end else if (hit_status) begin
      read_word[`STAT_BUSY] = busy;
      read_word[`STAT_DONE] = done;
      read_word[`STAT_REFUSED] = refused;
    end else if (hit_div) begin
      read_word[DIV_W-1:0] = half_cycles;
    end
  end

  // Read data is registered in the setup cycle so it stands during the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase) begin
      prdata <= read_word;
    end
  end

endmodule
`default_nettype wire

// file: spi_reg_host_sva.sv
// Checker for the serial register-access host, seeing only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "spi_host_cfg.svh"
module spi_reg_host_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic select_low_pin,
  input wire logic serial_clk_pin,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin
);
  logic [3:0] lanes;
  logic [3:0] frame_lanes;
  logic [6:0] rises;
  logic clk_q;
  logic sel_q;

  // Decoded APB events and the lane pattern that software last set.
  wire logic take = psel && penable;
  wire logic go_wr = take && pwrite && paddr == `OFS_CTRL && pwdata[`CTRL_GO];
  wire logic lanes_ok = lanes inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  wire logic mapped = paddr inside {`OFS_CTRL, `OFS_TARGET, `OFS_WDATA, `OFS_RDATA, `OFS_STATUS, `OFS_DIV};
  wire logic [6:0] want_rises = 7'h10 + 7'h08 * 7'($countones(frame_lanes));

  // Lanes are latched at frame start so that a later TARGET write cannot skew the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lanes <= 4'h3;
      frame_lanes <= 4'h3;
      rises <= 7'h00;
      clk_q <= 1'b0;
      sel_q <= 1'b1;
    end else begin
      clk_q <= serial_clk_pin;
      sel_q <= select_low_pin;
      if (take && pwrite && paddr == `OFS_TARGET) lanes <= pwdata[15:12];
      if (sel_q && !select_low_pin) begin
        frame_lanes <= lanes;
        rises <= 7'h00;
      end else if (serial_clk_pin && !clk_q) rises <= rises + 7'h01;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence opened_s; $fell(select_low_pin); endsequence
  sequence stay_idle_s; select_low_pin [*2]; endsequence

  idle_clk_low_a: assert property (select_low_pin |-> !serial_clk_pin)
    else $error("serial clock high outside a frame");
  frame_opened_a: assert property (opened_s |-> $past(go_wr))
    else $error("select fell without a start command");
  opcode_first_a: assert property (opened_s |-> serial_in_pin == $past(pwdata[`CTRL_WRITE]))
    else $error("first serial bit is not the opcode");
  lanes_refused_a: assert property (go_wr && !lanes_ok && select_low_pin |=> stay_idle_s)
    else $error("frame started with an illegal lane pattern");
  data_held_a: assert property (serial_clk_pin && $past(serial_clk_pin) |-> $stable(serial_in_pin))
    else $error("serial input moved while clock high");
  frame_length_a: assert property ($rose(select_low_pin) |-> rises == want_rises)
    else $error("wrong number of clock pulses in frame");
  close_clk_low_a: assert property ($rose(select_low_pin) |-> !$past(serial_clk_pin))
    else $error("select rose with clock high");
  unmapped_err_a: assert property (take && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  ready_now_a: assert property (psel && !penable |=> pready)
    else $error("access phase inserted wait states");
endmodule
bind spi_reg_host spi_reg_host_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .select_low_pin(select_low_pin), .serial_clk_pin(serial_clk_pin), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin));
`default_nettype wire

// file: spi_dev_model.sv
// Behavioural device model: serial register port over a 512-dword register file.
`timescale 1ns/100ps
`default_nettype none
module spi_dev_model #(
  parameter logic [15:0] CFG_STATUS = 16'h0002
) (
  input wire logic select_low_pin,
  input wire logic serial_clk_pin,
  input wire logic serial_in_pin,
  input wire logic fast_strap,
  output logic serial_out_pin,
  output logic [7:0] proto_errs
);
  // CFG_STATUS is an arbitrary strap readback value.
  logic [31:0] mem [512];
  logic [15:0] cmd = 16'h0;
  logic [7:0] byte_q = 8'h0;
  logic active = 1'b0;
  int cnt = 0;
  int first = 0;
  int lane;

  // No reset pin here, so registers start cleared.
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    proto_errs = 8'h0;
    serial_out_pin = 1'b0;
  end

  // Over-long frames see a flipped line, never a held bit.
  function automatic logic out_bit(input int j);
    logic [31:0] w;
    w = mem[cmd[14:6]];
    if (cmd[14:6] == 9'h036) w[15:0] = CFG_STATUS;
    if (first + j / 8 > 3) return ~serial_out_pin;
    return w[(first + j / 8) * 8 + 7 - j % 8];
  endfunction

  ////////////////////////////////////////
  // Each select-low period is one operation; the output line is flipped at its end.
  always @(negedge select_low_pin) begin
    cnt = 0;
    active = 1'b1;
  end
  always @(posedge select_low_pin) begin
    if (active && cnt != 16 + 8 * $countones(cmd[5:2])) proto_errs++;
    active = 1'b0;
    serial_out_pin = ~serial_out_pin;
  end

  // Inputs are taken on the rising clock; only whole bytes reach a register.
  always @(posedge serial_clk_pin) begin
    if (select_low_pin !== 1'b0) proto_errs++;
    else begin
      if (cnt < 16) cmd = {cmd[14:0], serial_in_pin};
      if (cnt == 15) begin
        first = cmd[2] ? 0 : cmd[3] ? 1 : cmd[4] ? 2 : 3;
        if (!(cmd[5:2] inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf}) || cmd[1:0] != 2'h0) proto_errs++;
      end
      if (cnt >= 16 && fast_strap) serial_out_pin = out_bit(cnt - 16);
      if (cnt >= 16) byte_q = {byte_q[6:0], serial_in_pin};
      lane = first + (cnt - 16) / 8;
      if (cnt >= 16 && (cnt - 16) % 8 == 7 && cmd[15] && lane < 4 && !(cmd[14:6] == 9'h036 && lane < 2))
        mem[cmd[14:6]][lane * 8 +: 8] = byte_q;
      cnt++;
    end
  end

  // Low-speed strap moves the output on the falling clock.
  always @(negedge serial_clk_pin)
    if (select_low_pin === 1'b0 && !fast_strap && cnt >= 16) serial_out_pin = out_bit(cnt - 16);
endmodule
`default_nettype wire

// file: spi_reg_host_test.sv
// Self-checking bench: APB programs the host, which talks to the device model.
`timescale 1ns/100ps
`default_nettype none
`include "spi_host_cfg.svh"
module spi_reg_host_test;
  localparam logic [15:0] cfg_value = 16'h0002; // Arbitrary strap readback.
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fast_strap = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, select_low_pin, serial_clk_pin, serial_in_pin, serial_out_pin;
  logic [7:0] proto_errs;
  int n_errors = 0;
  int tests_run = 0;
  logic [11:0] rst_addr [6] = '{`OFS_CTRL, `OFS_TARGET, `OFS_RDATA, `OFS_STATUS, `OFS_DIV, 12'h018};
  logic [31:0] rst_val [6] = '{32'h0, `TARGET_RESET, 32'h0, 32'h0, {24'h0, `DIV_RESET}, 32'h0};
  logic [3:0] lanes_tab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};

  always #20 pclk = ~pclk;

  spi_reg_host #(.DIV_W(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_low_pin(select_low_pin), .serial_clk_pin(serial_clk_pin), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin));
  spi_dev_model #(.CFG_STATUS(cfg_value)) dev (.select_low_pin(select_low_pin),
    .serial_clk_pin(serial_clk_pin), .serial_in_pin(serial_in_pin), .fast_strap(fast_strap),
    .serial_out_pin(serial_out_pin), .proto_errs(proto_errs));

  ////////////////////////////////////////
  // Verdict and end of run, shared by the main sequence and the watchdog.
  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) check(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // Polls STATUS under a bound until done is set.
  task automatic wait_done(output logic [31:0] s);
    logic e;
    s = 32'h0;
    for (int n = 0; n < 400 && s[`STAT_DONE] !== 1'b1; n++) apb(1'b0, `OFS_STATUS, 32'h0, s, e);
  endtask

  // A whole serial operation: target, data, start, wait, clear, fetch.
  task automatic frame(input logic op, input logic [8:0] dw, input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] q);
    logic [31:0] s;
    logic e;
    wr(`OFS_TARGET, {16'h0, be, 1'b0, dw, 2'h0});
    wr(`OFS_WDATA, d);
    wr(`OFS_CTRL, {29'h0, fast_strap, op, 1'b1});
    wait_done(s);
    check(s, 32'h2);
    wr(`OFS_STATUS, 32'h2);
    apb(1'b0, `OFS_RDATA, 32'h0, q, e);
  endtask

  function automatic logic [31:0] mask(input logic [3:0] b);
    mask = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  // Watchdog sized well above the roughly nine thousand cycles the tests need.
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    finish_test();
  end

  // Main sequence.
  initial begin
    logic [31:0] q, d;
    logic e;
    logic [8:0] dw;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rst_addr[i], 32'h0, q, e);
      check(q, rst_val[i]);
      check({31'h0, e}, {31'h0, i == 5});
    end
    wr(`OFS_RDATA, 32'hffff_ffff);
    apb(1'b0, `OFS_RDATA, 32'h0, q, e);
    check(q, 32'h0);
    for (int f = 0; f < 2; f++) begin
      // Low-speed pass keeps the reset divider, so the clock stays high over several samples.
      if (f == 1) wr(`OFS_DIV, 32'h1);
      fast_strap <= f[0];
      for (int i = 0; i < 7; i++) begin
        dw = (i == 6) ? 9'h1ff - 9'(f) : 9'(i + 1 + 8 * f);
        d = 32'h1b2c_3d4e ^ (32'h0101_0101 * 32'(i + 8 * f + 1));
        frame(1'b1, dw, lanes_tab[i], d, q);
        frame(1'b0, dw, 4'hf, 32'h0, q);
        check(q, d & mask(lanes_tab[i]));
        frame(1'b0, dw, lanes_tab[i], 32'h0, q);
        check(q, d & mask(lanes_tab[i]));
      end
    end
    frame(1'b1, 9'h036, 4'hf, 32'ha5a5_5a5a, q);
    frame(1'b0, 9'h036, 4'hf, 32'h0, q);
    check(q, {16'ha5a5, cfg_value});
    wr(`OFS_TARGET, {16'h0, 4'h5, 12'h0});
    wr(`OFS_CTRL, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0, q, e);
    check(q, 32'h4);
    wr(`OFS_STATUS, 32'h4);
    wr(`OFS_TARGET, {16'h0, 4'h1, 1'b0, 9'h002, 2'h0});
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0, q, e);
    check(q, 32'h5);
    wait_done(q);
    check(q, 32'h6);
    wr(`OFS_STATUS, 32'h6);
    apb(1'b0, `OFS_STATUS, 32'h0, q, e);
    check(q, 32'h0);
    check({24'h0, proto_errs}, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
